// [rtl/kms_debounce.sv]
// one key debouncer: glitch blackout, plus minimum hold time for a press only, counted in 2 ms ticks
// assumes tick is a one-cycle enable and raw is sampled once per scan step
`timescale 1ns/1ps
module kms_debounce #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // timing
    input  wire logic             tick,
    input  wire logic [CNT_W-1:0] glitch_ticks,
    input  wire logic [CNT_W-1:0] min_ticks,
    // sample
    input  wire logic             raw,
    // result
    output logic                  stable,
    output logic                  rise,
    output logic                  fall
);
    typedef struct packed {
        logic             stable;
        logic             cand;
        logic [CNT_W:0]   cnt;
        logic             rise;
        logic             fall;
    } kmd_state_t;

    kmd_state_t s;
    kmd_state_t next_s;

    always_comb begin
        next_s      = s;
        next_s.rise = 1'b0;
        next_s.fall = 1'b0;
        if (raw == s.stable) begin
            // short excursions are discarded
            next_s.cnt  = '0;
            next_s.cand = s.stable;
        end else if (raw != s.cand) begin
            next_s.cand = raw;
            next_s.cnt  = '0;
        end else if (tick) begin
            // a press must outlast blackout plus minimum hold, a release only the blackout
            if ((s.cand && ({1'b0, s.cnt[CNT_W-1:0]} + 1'b1 >= {1'b0, glitch_ticks} + {1'b0, min_ticks}))
                || (!s.cand && (s.cnt[CNT_W-1:0] + 1'b1 >= glitch_ticks))) begin
                next_s.stable = s.cand;
                next_s.rise   = s.cand;
                next_s.fall   = !s.cand;
                next_s.cnt    = '0;
            end else if (s.cnt[CNT_W-1:0] != '1) begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign stable = s.stable;
    assign rise   = s.rise;
    assign fall   = s.fall;

endmodule : kms_debounce

// [rtl/kms_pin_cell.sv]
// one gpio cell: three modes, pad enables derived from mode and scan override
// assumes pads resolve their own pull-up from pad_pu
`timescale 1ns/1ps
module kms_pin_cell (
    // configuration
    input  wire logic [1:0] mode,
    input  wire logic       sw_out,
    // scanner override
    input  wire logic       scan_own,
    input  wire logic       scan_low,
    // pad
    output logic            pad_o,
    output logic            pad_oe,
    output logic            pad_pu
);
    import kms_pkg::*;

    always_comb begin
        if (scan_own) begin
            // driven low or floated with pull-up
            pad_o  = 1'b0;
            pad_oe = scan_low;
            pad_pu = !scan_low;
        end else begin
            pad_o  = sw_out;
            pad_oe = (mode == PM_OUT_PP);
            pad_pu = (mode == PM_IN_PULLUP) || (mode == 2'h3);
        end
    end

endmodule : kms_pin_cell

// [rtl/kms_scanner.sv]
// key matrix scanner top: apb registers, walking-zero column scan, debounce, irq, wake
// assumes apb master in the MCLK domain and pad inputs synchronous to MCLK
`timescale 1ns/1ps
module kms_scanner #(
    parameter int STEP_CYC  = kms_pkg::STEP_CYCLES,
    parameter int DWELL_CYC = kms_pkg::COL_DWELL_CYC
) (
    // clock and reset
    input  wire logic                         MCLK,
    input  wire logic                         RST_B,
    // apb
    input  wire logic                         PSEL,
    input  wire logic                         PENABLE,
    input  wire logic                         PWRITE,
    input  wire logic [11:0]                  PADDR,
    input  wire logic [31:0]                  PWDATA,
    output logic      [31:0]                  PRDATA,
    output logic                              PREADY,
    output logic                              PSLVERR,
    // matrix pads
    input  wire logic [kms_pkg::NUM_ROWS-1:0] MATRIX_ROW_INPUTS,
    output logic      [kms_pkg::NUM_ROWS-1:0] ROW_PULLUP,
    output logic      [kms_pkg::NUM_COLS-1:0] MATRIX_COLUMN_DRIVERS_O,
    output logic      [kms_pkg::NUM_COLS-1:0] MATRIX_COLUMN_DRIVERS_OE,
    output logic      [kms_pkg::NUM_COLS-1:0] MATRIX_COLUMN_DRIVERS_PU,
    // system
    output logic                              IRQ,
    output logic                              WAKE_REQ,
    output logic                              KEY_RESET_REQ
);
    import kms_pkg::*;

    localparam int NR = NUM_ROWS;
    localparam int NC = NUM_COLS;
    localparam int NK = NUM_KEYS;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        kms_state_t          st;
        logic [3:0]          ctrl;
        logic [15:0]         deb;
        logic [STAT_W-1:0]   status;
        logic [STAT_W-1:0]   mask;
        logic [2*NC-1:0]     pin_mode;
        logic [NC-1:0]       pin_out;
        logic [1:0]          cause;
        logic [3:0]          col;
        logic [31:0]         tmr;
        logic [31:0]         dwell;
        logic [NK-1:0]       raw;
        logic [6:0]          last_key;
        logic                last_dir;
        logic [31:0]         prdata;
        logic                kreset;
    } kms_regs_t;

    kms_regs_t r;
    kms_regs_t next_r;

    logic [NK-1:0] stable;
    logic [NK-1:0] rise;
    logic [NK-1:0] fall;
    logic          tick;
    logic          any_row_low;
    logic [3:0]    n_pressed;

    assign tick        = (r.tmr == 32'(STEP_CYC - 1));
    assign any_row_low = ~&MATRIX_ROW_INPUTS;

    // ****************************************
    // per-key debounce
    // ****************************************
    for (genvar k = 0; k < NK; k++) begin : g_key
        kms_debounce #(
            .CNT_W (DEB_FIELD_W)
        ) u_deb (
            .clk          (MCLK),
            .rst_b        (RST_B),
            .tick         (tick),
            .glitch_ticks (r.deb[DEB_GLITCH_LSB +: DEB_FIELD_W]),
            .min_ticks    (r.deb[DEB_MINPR_LSB +: DEB_FIELD_W]),
            .raw          (r.raw[k]),
            .stable       (stable[k]),
            .rise         (rise[k]),
            .fall         (fall[k])
        );
    end

    // ****************************************
    // column pads
    // ****************************************
    for (genvar c = 0; c < NC; c++) begin : g_col
        logic scan_low;
        assign scan_low = (r.st == ST_SLEEP) || (r.st == ST_DRIVE && r.col == 4'(c))
                          || (r.st == ST_SAMPLE && r.col == 4'(c));
        kms_pin_cell u_pin (
            .mode     (r.pin_mode[2*c +: 2]),
            .sw_out   (r.pin_out[c]),
            .scan_own (r.ctrl[CTRL_SCAN_EN] || r.st == ST_SLEEP),
            .scan_low (scan_low),
            .pad_o    (MATRIX_COLUMN_DRIVERS_O[c]),
            .pad_oe   (MATRIX_COLUMN_DRIVERS_OE[c]),
            .pad_pu   (MATRIX_COLUMN_DRIVERS_PU[c])
        );
    end

    // rows are always pulled-up inputs
    assign ROW_PULLUP = '1;

    always_comb begin
        n_pressed = '0;
        for (int k = 0; k < NK; k++) begin
            n_pressed = n_pressed + {3'h0, stable[k] && n_pressed != 4'hf};
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic          wr;
        logic          rd;
        logic [31:0]   rdv;
        logic [STAT_W-1:0] ev;
        wr     = PSEL && PENABLE && PWRITE;
        rd     = PSEL && !PENABLE && !PWRITE;
        rdv    = 32'h0;
        ev     = '0;
        next_r = r;

        // 2 ms step timer
        next_r.tmr = tick ? 32'h0 : r.tmr + 32'h1;

        // scan sequencing
        case (r.st)
            ST_IDLE: begin
                if (r.ctrl[CTRL_SLEEP]) begin
                    next_r.st = ST_SLEEP;
                end else if (r.ctrl[CTRL_SCAN_EN]) begin
                    next_r.st    = ST_DRIVE;
                    next_r.col   = 4'h0;
                    next_r.dwell = 32'h0;
                end
            end
            ST_DRIVE: begin
                // let the column settle before sampling
                next_r.dwell = r.dwell + 32'h1;
                if (r.dwell == 32'(DWELL_CYC - 1)) begin
                    next_r.st = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                for (int i = 0; i < NR; i++) begin
                    next_r.raw[i*NC + int'(r.col)] = !MATRIX_ROW_INPUTS[i];
                end
                next_r.dwell = 32'h0;
                if (r.col == 4'(NC - 1) || r.ctrl[CTRL_SLEEP]) begin
                    next_r.col = 4'h0;
                    next_r.st  = ST_IDLE;
                end else begin
                    next_r.col = r.col + 4'h1;
                    next_r.st  = ST_DRIVE;
                end
            end
            ST_SLEEP: begin
                // all columns low, any key pulls a row low
                if (any_row_low && r.ctrl[CTRL_WAKE_EN]) begin
                    ev[STAT_WAKE]         = 1'b1;
                    next_r.cause          = CAUSE_KEYSCAN;
                    next_r.ctrl[CTRL_SLEEP] = 1'b0;
                    next_r.kreset         = r.ctrl[CTRL_KRST_EN];
                    next_r.st             = ST_IDLE;
                end else if (!r.ctrl[CTRL_SLEEP]) begin
                    next_r.st = ST_IDLE;
                end
            end
            default: next_r.st = ST_IDLE;
        endcase

        // events from debounced keys
        if (|rise) begin
            ev[STAT_PRESS] = 1'b1;
        end
        if (|fall) begin
            ev[STAT_RELEASE] = 1'b1;
        end
        if (n_pressed > 4'(MAX_CONCURRENT)) begin
            ev[STAT_OVERFLOW] = 1'b1;
        end
        for (int k = 0; k < NK; k++) begin
            if (rise[k] || fall[k]) begin
                next_r.last_key = 7'(k);
                next_r.last_dir = rise[k];
            end
        end

        // apb write
        if (wr) begin
            if (PADDR == REG_CTRL) begin
                next_r.ctrl = PWDATA[3:0];
            end else if (PADDR == REG_DEBOUNCE) begin
                next_r.deb = PWDATA[15:0];
            end else if (PADDR == REG_STATUS) begin
                next_r.status = r.status & ~PWDATA[STAT_W-1:0];
            end else if (PADDR == REG_IRQ_MASK) begin
                next_r.mask = PWDATA[STAT_W-1:0];
            end else if (PADDR == REG_PIN_MODE) begin
                next_r.pin_mode = PWDATA[2*NC-1:0];
            end else if (PADDR == REG_PIN_OUT) begin
                next_r.pin_out = PWDATA[NC-1:0];
            end else if (PADDR == REG_RESET_CAUSE && !ev[STAT_WAKE]) begin
                next_r.cause  = CAUSE_NONE;
                next_r.kreset = 1'b0;
            end
        end
        // set wins over a write-one clear in the same cycle
        next_r.status = next_r.status | ev;

        // apb read data captured in setup
        if (PADDR == REG_CTRL) begin
            rdv = {28'h0, r.ctrl};
        end else if (PADDR == REG_DEBOUNCE) begin
            rdv = {16'h0, r.deb};
        end else if (PADDR == REG_STATUS) begin
            rdv = {28'h0, r.status};
        end else if (PADDR == REG_IRQ_MASK) begin
            rdv = {28'h0, r.mask};
        end else if (PADDR == REG_KEYS0) begin
            rdv = stable[31:0];
        end else if (PADDR == REG_KEYS1) begin
            rdv = stable[63:32];
        end else if (PADDR == REG_KEYS2) begin
            rdv = {8'h0, stable[NK-1:64]};
        end else if (PADDR == REG_PIN_MODE) begin
            rdv = {10'h0, r.pin_mode};
        end else if (PADDR == REG_PIN_OUT) begin
            rdv = {21'h0, r.pin_out};
        end else if (PADDR == REG_RESET_CAUSE) begin
            rdv = {30'h0, r.cause};
        end else if (PADDR == REG_EVENT_KEY) begin
            rdv = {20'h0, n_pressed, r.last_dir, r.last_key};
        end
        if (rd) begin
            next_r.prdata = rdv;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            r          <= '0;
            r.st       <= ST_IDLE;
            r.ctrl     <= CTRL_RST;
            r.deb      <= DEBOUNCE_RST;
            r.mask     <= MASK_RST;
            // every pin comes up as pulled-up input
            r.pin_mode <= {NC{PM_IN_PULLUP}};
            r.cause    <= CAUSE_NONE;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign PRDATA        = r.prdata;
    assign PREADY        = 1'b1;
    assign PSLVERR       = 1'b0;
    assign IRQ           = |(r.status & r.mask);
    assign WAKE_REQ      = r.status[STAT_WAKE];
    assign KEY_RESET_REQ = r.kreset;

endmodule : kms_scanner

// [shared/kms_pkg.sv]
// key matrix scanner package: register map, field positions, reset values, timing
// assumes a 200 MHz system clock and a 32-bit apb register bus
package kms_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int NUM_ROWS = 8;
    localparam int NUM_COLS = 11;
    localparam int NUM_KEYS = NUM_ROWS * NUM_COLS;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS  = 5;
    localparam int STEP_TIME_NS   = 2000000;
    localparam int STEP_CYCLES    = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam int COL_DWELL_NS   = 10000;
    localparam int COL_DWELL_CYC  = COL_DWELL_NS / CLK_PERIOD_NS;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [11:0] REG_CTRL     = 12'h000;
    localparam logic [11:0] REG_DEBOUNCE = 12'h004;
    localparam logic [11:0] REG_STATUS   = 12'h008;
    localparam logic [11:0] REG_IRQ_MASK = 12'h00c;
    localparam logic [11:0] REG_KEYS0    = 12'h010;
    localparam logic [11:0] REG_KEYS1    = 12'h014;
    localparam logic [11:0] REG_KEYS2    = 12'h018;
    localparam logic [11:0] REG_PIN_MODE = 12'h01c;
    localparam logic [11:0] REG_PIN_OUT  = 12'h020;
    localparam logic [11:0] REG_RESET_CAUSE = 12'h024;
    localparam logic [11:0] REG_EVENT_KEY = 12'h028;

    // ****************************************
    // fields
    // ****************************************
    localparam int CTRL_SCAN_EN   = 0;
    localparam int CTRL_WAKE_EN   = 1;
    localparam int CTRL_SLEEP     = 2;
    localparam int CTRL_KRST_EN   = 3;
    localparam int STAT_PRESS     = 0;
    localparam int STAT_RELEASE   = 1;
    localparam int STAT_WAKE      = 2;
    localparam int STAT_OVERFLOW  = 3;
    localparam int STAT_W         = 4;
    localparam int DEB_GLITCH_LSB = 0;
    localparam int DEB_MINPR_LSB  = 8;
    localparam int DEB_FIELD_W    = 8;
    localparam int MAX_CONCURRENT = 8;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [3:0]  CTRL_RST      = 4'h0;
    localparam logic [15:0] DEBOUNCE_RST  = 16'h0101;
    localparam logic [3:0]  MASK_RST      = 4'h0;
    localparam logic [1:0]  CAUSE_NONE    = 2'h0;
    localparam logic [1:0]  CAUSE_KEYSCAN = 2'h1;

    // pin modes, two bits per pin
    localparam logic [1:0] PM_IN_PULLUP = 2'h0;
    localparam logic [1:0] PM_OUT_PP    = 2'h1;
    localparam logic [1:0] PM_IN_NOPULL = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_DRIVE, ST_SAMPLE, ST_SLEEP} kms_state_t;

endpackage : kms_pkg

// [tb/kms_matrix_model.sv]
// passive switch matrix: a closed key joins its row to its column
// assumes the bench holds keys_down and the scanner owns the column pads
`timescale 1ns/1ps
module kms_matrix_model (
    // clock
    input  wire logic                         clk,
    // pads of the scanner
    input  wire logic [kms_pkg::NUM_COLS-1:0] col_o,
    input  wire logic [kms_pkg::NUM_COLS-1:0] col_oe,
    input  wire logic [kms_pkg::NUM_ROWS-1:0] row_pu,
    // switches
    input  wire logic [kms_pkg::NUM_KEYS-1:0] keys_down,
    // row levels
    output logic      [kms_pkg::NUM_ROWS-1:0] rows
);
    import kms_pkg::*;
    logic [NUM_ROWS-1:0] low;
    logic [NUM_ROWS-1:0] flip;
    always_comb begin
        low = '0;
        for (int r = 0; r < NUM_ROWS; r++) begin
            for (int c = 0; c < NUM_COLS; c++) begin
                if (keys_down[r*NUM_COLS+c] && col_oe[c] && !col_o[c]) begin
                    low[r] = 1'b1;
                end
            end
            // an unpulled idle row wanders instead of holding its last level
            rows[r] = low[r] ? 1'b0 : (row_pu[r] ? 1'b1 : flip[r]);
        end
    end
    always_ff @(posedge clk) begin
        flip <= ~rows;
    end
endmodule : kms_matrix_model

// [tb/kms_scanner_chk.sv]
// port checker for the key matrix scanner
// assumes one clock domain; control bits are tracked by snooping apb writes
`timescale 1ns/1ps
module kms_scanner_chk #(
    parameter int STEP_CYC  = 20,
    parameter int DWELL_CYC = 2
) (
    // clock and reset
    input wire logic                         MCLK,
    input wire logic                         RST_B,
    // apb
    input wire logic                         PSEL,
    input wire logic                         PENABLE,
    input wire logic                         PWRITE,
    input wire logic [11:0]                  PADDR,
    input wire logic [31:0]                  PWDATA,
    input wire logic [31:0]                  PRDATA,
    input wire logic                         PREADY,
    input wire logic                         PSLVERR,
    // matrix pads
    input wire logic [kms_pkg::NUM_ROWS-1:0] MATRIX_ROW_INPUTS,
    input wire logic [kms_pkg::NUM_ROWS-1:0] ROW_PULLUP,
    input wire logic [kms_pkg::NUM_COLS-1:0] MATRIX_COLUMN_DRIVERS_O,
    input wire logic [kms_pkg::NUM_COLS-1:0] MATRIX_COLUMN_DRIVERS_OE,
    input wire logic [kms_pkg::NUM_COLS-1:0] MATRIX_COLUMN_DRIVERS_PU,
    // system
    input wire logic                         IRQ,
    input wire logic                         WAKE_REQ,
    input wire logic                         KEY_RESET_REQ
);
    import kms_pkg::*;
    logic [10:0] oe;
    logic [10:0] o;
    logic [3:0]  ctrl_q;
    logic [2:0]  settle;
    logic [10:0] last_oe;
    logic        wake_d;
    logic        ctrl_wr;
    logic        wake_up;
    logic        scan_q;
    assign oe = MATRIX_COLUMN_DRIVERS_OE;
    assign o = MATRIX_COLUMN_DRIVERS_O;
    assign ctrl_wr = PSEL && PENABLE && PWRITE && PREADY && PADDR == REG_CTRL;
    assign wake_up = WAKE_REQ && !wake_d;
    // scan checks start once the walk has had time to take over the pads
    assign scan_q = ctrl_q[CTRL_SCAN_EN] && !ctrl_q[CTRL_SLEEP] && settle == 3'h7;
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_q <= CTRL_RST;
            settle <= 3'h0;
            last_oe <= '0;
            wake_d <= 1'b0;
        end else begin
            wake_d <= WAKE_REQ;
            if (ctrl_wr) ctrl_q <= PWDATA[3:0];
            else if (wake_up) ctrl_q[CTRL_SLEEP] <= 1'b0;
            if (ctrl_wr || wake_up) settle <= 3'h0;
            else if (settle != 3'h7) settle <= settle + 3'h1;
            if (!scan_q) last_oe <= '0;
            else if (oe != '0) last_oe <= oe;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    property p_reset_pins;
        $rose(RST_B) |-> oe == '0 && &MATRIX_COLUMN_DRIVERS_PU && !IRQ && !KEY_RESET_REQ;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pins not at reset state");
    property p_row_pu;
        ROW_PULLUP == '1;
    endproperty
    a_row_pu: assert property (p_row_pu) else $error("row pull-up off");
    property p_one_col;
        scan_q |-> $onehot0(oe);
    endproperty
    a_one_col: assert property (p_one_col) else $error("more than one column driven");
    property p_drive_low;
        scan_q |-> (oe & o) == '0;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("scanned column not low");
    property p_pull;
        scan_q |-> &(oe | MATRIX_COLUMN_DRIVERS_PU);
    endproperty
    a_pull: assert property (p_pull) else $error("idle column not pulled up");
    property p_order;
        scan_q && oe != '0 && last_oe != '0 && oe != last_oe |-> oe == (last_oe << 1) || (last_oe[10] && oe == 11'h001);
    endproperty
    a_order: assert property (p_order) else $error("column walk out of order");
    property p_sleep;
        ctrl_wr && PWDATA[CTRL_SLEEP] && MATRIX_ROW_INPUTS == '1 |-> ##[1:8] (&oe && o == '0);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not drive all columns low");
    property p_wake;
        ctrl_q[CTRL_WAKE_EN] && ctrl_q[CTRL_SLEEP] && &oe && o == '0 && MATRIX_ROW_INPUTS != '1 |-> ##[0:16] WAKE_REQ;
    endproperty
    a_wake: assert property (p_wake) else $error("key press in sleep gave no wake");
    property p_krst;
        $rose(KEY_RESET_REQ) |-> ctrl_q[CTRL_KRST_EN] && WAKE_REQ;
    endproperty
    a_krst: assert property (p_krst) else $error("reset request without enable");
    property p_irq_mask;
        PSEL && PENABLE && PWRITE && PADDR == REG_IRQ_MASK && PWDATA[3:0] == 4'h0 |=> !IRQ;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt still high");
endmodule : kms_scanner_chk

bind kms_scanner kms_scanner_chk #(.STEP_CYC(STEP_CYC), .DWELL_CYC(DWELL_CYC)) u_chk (
    .MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .MATRIX_ROW_INPUTS(MATRIX_ROW_INPUTS), .ROW_PULLUP(ROW_PULLUP),
    .MATRIX_COLUMN_DRIVERS_O(MATRIX_COLUMN_DRIVERS_O), .MATRIX_COLUMN_DRIVERS_OE(MATRIX_COLUMN_DRIVERS_OE),
    .MATRIX_COLUMN_DRIVERS_PU(MATRIX_COLUMN_DRIVERS_PU), .IRQ(IRQ), .WAKE_REQ(WAKE_REQ),
    .KEY_RESET_REQ(KEY_RESET_REQ)
);

// [tb/kms_scanner_tb_top.sv]
// self-checking bench for the key matrix scanner: apb tasks and key sequences
// assumes short tick and dwell parameters so a debounce takes tens of cycles
`timescale 1ns/1ps
module kms_scanner_tb_top;
    import kms_pkg::*;
    logic mclk = 1'b0;
    logic rst_b, psel, penable, pwrite, pready, pslverr, irq, wake_req, key_rst;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] rows, row_pu;
    logic [10:0] col_o, col_oe, col_pu;
    logic [87:0] keys;
    logic [31:0] pm;
    int fails, comparisons;
    always #2.5 mclk = ~mclk;
    kms_scanner #(.STEP_CYC(20), .DWELL_CYC(2)) uut (
        .MCLK(mclk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MATRIX_ROW_INPUTS(rows),
        .ROW_PULLUP(row_pu), .MATRIX_COLUMN_DRIVERS_O(col_o), .MATRIX_COLUMN_DRIVERS_OE(col_oe),
        .MATRIX_COLUMN_DRIVERS_PU(col_pu), .IRQ(irq), .WAKE_REQ(wake_req), .KEY_RESET_REQ(key_rst));
    kms_matrix_model u_keys (.clk(mclk), .col_o(col_o), .col_oe(col_oe), .row_pu(row_pu),
        .keys_down(keys), .rows(rows));
    task automatic wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin fails++; $display("BAD t=%0t no pready", $time); wrap_up(); end
    endtask : apb
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wreg
    task automatic rreg(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rreg
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic set_keys(input logic [87:0] k);
        @(posedge mclk);
        keys <= k;
    endtask : set_keys
    // sel 0 waits for irq, 1 for wake_req
    task automatic wait_hi(input int sel, input int lim);
        int n;
        n = 0;
        while (((sel == 0) ? irq : wake_req) !== 1'b1 && n < lim) begin @(negedge mclk); n++; end
        if (n >= lim) begin fails++; $display("BAD t=%0t wait ran out", $time); wrap_up(); end
    endtask : wait_hi
    initial begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0; keys = '0;
        fails = 0; comparisons = 0;
        pm = 32'({2'h3, PM_IN_PULLUP, PM_IN_NOPULL, PM_OUT_PP});
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        rreg(REG_CTRL, 32'(CTRL_RST));
        rreg(REG_DEBOUNCE, 32'(DEBOUNCE_RST));
        rreg(REG_IRQ_MASK, 32'(MASK_RST));
        rreg(REG_PIN_MODE, 32'h0);
        rreg(REG_RESET_CAUSE, 32'(CAUSE_NONE));
        rreg(12'h0fc, 32'h0);
        cyc(1);
        check(32'(col_oe), 32'h0);
        check(32'(col_pu), 32'h7ff);
        $display("test reset done");
        wreg(REG_PIN_MODE, pm);
        wreg(REG_PIN_OUT, 32'h1);
        cyc(2);
        check(32'(col_oe[3:0]), 32'h1);
        check(32'(col_o[0]), 32'h1);
        check(32'(col_pu[3:1]), 32'h6);
        wreg(REG_PIN_OUT, 32'h0);
        cyc(2);
        check(32'(col_o[0]), 32'h0);
        rreg(REG_PIN_MODE, pm);
        $display("test pins done");
        wreg(REG_IRQ_MASK, 32'h3);
        wreg(REG_CTRL, 32'h1);
        set_keys((88'h1 << 87) | 88'h1);
        wait_hi(0, 3000);
        cyc(99);
        rreg(REG_STATUS, 32'h1);
        rreg(REG_KEYS0, 32'h1);
        rreg(REG_KEYS2, 32'h0080_0000);
        apb(1'b0, REG_EVENT_KEY, 32'h0);
        check(32'(rd[11:8]), 32'h2);
        wreg(REG_IRQ_MASK, 32'h0);
        cyc(1);
        check(32'(irq), 32'h0);
        wreg(REG_IRQ_MASK, 32'h3);
        cyc(1);
        check(32'(irq), 32'h1);
        wreg(REG_STATUS, 32'h1);
        cyc(1);
        check(32'(irq), 32'h0);
        set_keys(88'h0);
        wait_hi(0, 3000);
        cyc(99);
        rreg(REG_STATUS, 32'h2);
        rreg(REG_KEYS0, 32'h0);
        rreg(REG_KEYS2, 32'h0);
        wreg(REG_STATUS, 32'hf);
        set_keys(88'h1ff);
        wait_hi(0, 3000);
        cyc(100);
        apb(1'b0, REG_STATUS, 32'h0);
        check(32'(rd[STAT_OVERFLOW]), 32'h1);
        set_keys(88'h0);
        cyc(300);
        wreg(REG_STATUS, 32'hf);
        $display("test scan done");
        wreg(REG_DEBOUNCE, 32'h0303);
        rreg(REG_DEBOUNCE, 32'h0303);
        set_keys(88'h1 << 40);
        cyc(25);
        set_keys(88'h0);
        cyc(300);
        check(32'(irq), 32'h0);
        rreg(REG_KEYS1, 32'h0);
        set_keys(88'h1 << 40);
        cyc(80);
        check(32'(irq), 32'h0);
        wait_hi(0, 2000);
        rreg(REG_KEYS1, 32'h100);
        wreg(REG_STATUS, 32'hf);
        set_keys(88'h0);
        cyc(400);
        $display("test debounce done");
        wreg(REG_CTRL, 32'h0);
        wreg(REG_STATUS, 32'hf);
        wreg(REG_IRQ_MASK, 32'h4);
        wreg(REG_CTRL, 32'he);
        cyc(8);
        check(32'(col_oe), 32'h7ff);
        check(32'(col_o), 32'h0);
        set_keys(88'h1 << 60);
        wait_hi(1, 200);
        cyc(2);
        check(32'(key_rst), 32'h1);
        check(32'(irq), 32'h1);
        rreg(REG_RESET_CAUSE, 32'(CAUSE_KEYSCAN));
        rreg(REG_CTRL, 32'ha);
        rreg(REG_PIN_MODE, pm);
        check(32'(col_oe[3:0]), 32'h1);
        wreg(REG_RESET_CAUSE, 32'h0);
        cyc(1);
        check(32'(key_rst), 32'h0);
        rreg(REG_RESET_CAUSE, 32'(CAUSE_NONE));
        wreg(REG_STATUS, 32'h4);
        cyc(1);
        check(32'(wake_req), 32'h0);
        set_keys(88'h0);
        $display("test sleep done");
        wrap_up();
    end
endmodule : kms_scanner_tb_top
